// ===== rtl/cdis_params.svh
`ifndef CDIS_PARAMS_SVH
`define CDIS_PARAMS_SVH
`define CDIS_ADDR_W 16
`define CDIS_DATA_W 8
`define CDIS_FIFO_DEPTH 16
`define CDIS_BYTE_RST 8'h00
`define CDIS_ADDR_RST 16'h0000
`define CDIS_STAT_W 8
`define CDIS_STAT_RST 8'h00
`endif

// ===== rtl/cdis_pkg.sv
`include "cdis_params.svh"
package cdis_pkg;
  typedef logic [`CDIS_DATA_W-1:0] cdis_byte_t;
  typedef logic [`CDIS_ADDR_W-1:0] cdis_addr_t;
  typedef logic [`CDIS_STAT_W-1:0] cdis_stat_t;
  typedef enum logic [2:0] {
    CDIS_IDLE = 3'b001,
    CDIS_MEMIO = 3'b010,
    CDIS_PANEL = 3'b100
  } cdis_src_t;
endpackage

// ===== rtl/cdis_fifo.sv
// The output buffer lives beside the steering logic, in the steering file.

// ===== rtl/cdis_steer.sv
// Notes on behaviour
// - Sixteen address lines go out toward memory and I/O, registered.
// - Status follows the address, one cycle after it is placed.
// - Memory/IO drivers enable only with strobe high and takeover low.
// - Enabled drivers pass the input byte onto the two-way data bus.
// - Takeover high blocks memory/IO input and selects panel input.
// - Panel byte reaches the processor only in the cycle after the strobe.
// - Written data appears on eight dedicated output lines.
// - Panel sees the same output lines for display.
// - Ready low holds the processor waiting; ready high lets it run.
// - Wait request is retimed through one flip-flop before ready.
`include "cdis_params.svh"

module cdis_steer
  import cdis_pkg::*;
#(
  parameter int FIFO_DEPTH = `CDIS_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Processor side.
  input wire cdis_pkg::cdis_addr_t cpu_addr,
  input wire cdis_pkg::cdis_stat_t cpu_status,
  input wire cdis_pkg::cdis_byte_t cpu_wdata,
  input wire logic cpu_wvalid,
  output logic cpu_wready,
  input wire logic data_bus_in_strobe,
  output logic cpu_ready,
  // Two-way data bus, split into its three signals.
  input wire cdis_pkg::cdis_byte_t bidir_data_bus_i,
  output cdis_pkg::cdis_byte_t bidir_data_bus_o,
  output logic bidir_data_bus_oe,
  // System bus side.
  output cdis_pkg::cdis_addr_t address_lines,
  output cdis_pkg::cdis_stat_t status_lines,
  output cdis_pkg::cdis_byte_t processor_output_byte,
  output logic output_byte_valid,
  input wire logic output_byte_taken,
  input wire cdis_pkg::cdis_byte_t memory_io_input_byte,
  input wire logic wait_request_input,
  // Front panel side.
  input wire logic panel_takeover,
  input wire cdis_pkg::cdis_byte_t panel_input_byte
);
  import cdis_pkg::*;

  // ==========================================================
  // Address and status
  // ==========================================================
  cdis_addr_t addr_ff;
  cdis_stat_t stat_ff;
  cdis_stat_t stat_pend_ff;

  // Status is held back one cycle so the address is always stable first.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= `CDIS_ADDR_RST;
      stat_pend_ff <= `CDIS_STAT_RST;
      stat_ff <= `CDIS_STAT_RST;
    end else begin
      addr_ff <= cpu_addr;
      stat_pend_ff <= cpu_status;
      stat_ff <= stat_pend_ff;
    end
  end
  assign address_lines = addr_ff;
  assign status_lines = stat_ff;

  // ==========================================================
  // Input steering
  // ==========================================================
  cdis_src_t src_ff;
  cdis_src_t nxt_src;
  cdis_byte_t bus_ff;
  cdis_byte_t nxt_bus;
  logic oe_ff;

  always_comb begin
    nxt_src = CDIS_IDLE;
    nxt_bus = `CDIS_BYTE_RST;
    case ({data_bus_in_strobe, panel_takeover})
      2'b10: begin
        nxt_src = CDIS_MEMIO;
        nxt_bus = memory_io_input_byte;
      end
      2'b11: begin
        nxt_src = CDIS_PANEL;
        nxt_bus = panel_input_byte;
      end
      default: begin
        nxt_src = CDIS_IDLE;
        nxt_bus = `CDIS_BYTE_RST;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_ff <= CDIS_IDLE;
      bus_ff <= `CDIS_BYTE_RST;
      oe_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
      bus_ff <= nxt_bus;
      oe_ff <= (nxt_src != CDIS_IDLE);
    end
  end
  assign bidir_data_bus_o = bus_ff;
  assign bidir_data_bus_oe = oe_ff;

  // ==========================================================
  // Output data path
  // ==========================================================
  // The FIFO lets the processor write ahead while a slow card or the panel
  // is still taking the previous byte; a full FIFO stalls the writer.
  cdis_byte_t fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  cdis_byte_t out_ff;
  logic out_valid_ff;

  assign fifo_pop = fifo_valid && (!out_valid_ff || output_byte_taken);

  cdis_fifo #(
    .WIDTH(`CDIS_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(cpu_wvalid),
    .in_ready(cpu_wready),
    .in_data(cpu_wdata),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_ff <= `CDIS_BYTE_RST;
      out_valid_ff <= 1'b0;
    end else begin
      if (fifo_pop) begin
        out_ff <= fifo_data;
        out_valid_ff <= 1'b1;
      end else if (output_byte_taken) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
  assign processor_output_byte = out_ff;
  assign output_byte_valid = out_valid_ff;

  // ==========================================================
  // Ready retiming
  // ==========================================================
  logic ready_ff;

  // One flop only: inputs are synchronous here, so no second stage is needed.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= wait_request_input;
    end
  end
  assign cpu_ready = ready_ff;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_addr_follow: assert property (@(posedge mclk) disable iff (!rst_b)
    address_lines == $past(cpu_addr))
    else $error("address lines do not follow processor address");
  chk_status_after_addr: assert property (@(posedge mclk) disable iff (!rst_b)
    ##2 status_lines == $past(cpu_status, 2))
    else $error("status not two cycles behind processor status");
  chk_memio_enable: assert property (@(posedge mclk) disable iff (!rst_b)
    (data_bus_in_strobe && !panel_takeover) |=> bidir_data_bus_oe && bidir_data_bus_o == $past(memory_io_input_byte))
    else $error("memory/IO byte not driven during strobe");
  chk_panel_select: assert property (@(posedge mclk) disable iff (!rst_b)
    (data_bus_in_strobe && panel_takeover) |=> bidir_data_bus_oe && bidir_data_bus_o == $past(panel_input_byte))
    else $error("panel byte not driven under takeover");
  chk_release_bus: assert property (@(posedge mclk) disable iff (!rst_b)
    !data_bus_in_strobe |=> !bidir_data_bus_oe && src_ff == CDIS_IDLE)
    else $error("bus driven without strobe");
  chk_one_source: assert property (@(posedge mclk) disable iff (!rst_b)
    bidir_data_bus_oe |-> $past(data_bus_in_strobe) && $onehot(src_ff))
    else $error("bus enable without strobe or with two sources");
  chk_ready_retime: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(wait_request_input) |=> cpu_ready)
    else $error("ready not retimed in one cycle");
  chk_wait_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    !wait_request_input [*2] |-> !cpu_ready)
    else $error("ready high while wait requested");
  chk_output_byte: assert property (@(posedge mclk) disable iff (!rst_b)
    fifo_pop |=> output_byte_valid && processor_output_byte == $past(fifo_data))
    else $error("output byte not presented");
  chk_out_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (output_byte_valid && !output_byte_taken) |=> output_byte_valid && $stable(processor_output_byte))
    else $error("output byte dropped before taken");

  cov_memio_read: cover property (@(posedge mclk) disable iff (!rst_b)
    data_bus_in_strobe && !panel_takeover ##1 bidir_data_bus_oe);
  cov_panel_read: cover property (@(posedge mclk) disable iff (!rst_b)
    data_bus_in_strobe && panel_takeover ##1 bidir_data_bus_oe);
  cov_fifo_full: cover property (@(posedge mclk) disable iff (!rst_b)
    cpu_wvalid && !cpu_wready);
  cov_wait_state: cover property (@(posedge mclk) disable iff (!rst_b)
    !cpu_ready ##1 cpu_ready);
endmodule

// ==========================================================
// Output buffer
// ==========================================================
module cdis_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic in_ready_ff;
  logic out_valid_ff;
  logic push;
  logic pop;

  // Both flags are registered from the next count, so the ready that the
  // writer sees comes straight from a flop without losing a cycle of throughput.
  assign push = in_valid && in_ready_ff;
  assign pop = out_valid_ff && out_ready;
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b1;
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
      out_valid_ff <= (nxt_count != '0);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_fifo_no_overflow: assert property (@(posedge mclk) disable iff (!rst_b)
    count_ff <= (AW+1)'(DEPTH))
    else $error("buffer count beyond its depth");
  chk_fifo_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_ready == (count_ff != (AW+1)'(DEPTH))) && (out_valid == (count_ff != '0)))
    else $error("buffer flags disagree with its count");
endmodule

// ===== bench/cdis_far_model.sv
module cdis_far_model
  import cdis_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Bench controls.
  input wire logic take_req,
  input wire logic stall,
  // Far side pins.
  output logic panel_takeover,
  output cdis_pkg::cdis_byte_t memory_io_input_byte,
  output cdis_pkg::cdis_byte_t panel_input_byte,
  output logic wait_request_input,
  output logic output_byte_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Far side
  // Fresh bytes each cycle, so a stale bus value seldom matches by luck.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      panel_takeover <= 1'h0;
      memory_io_input_byte <= 8'h00;
      panel_input_byte <= 8'h00;
      wait_request_input <= 1'h0;
      output_byte_taken <= 1'h0;
    end else begin
      panel_takeover <= take_req;
      memory_io_input_byte <= 8'($urandom);
      panel_input_byte <= 8'($urandom);
      wait_request_input <= 1'($urandom);
      output_byte_taken <= !stall && 1'($urandom);
    end
  end
endmodule

// ===== bench/cpu_data_input_steering_test.sv
module cpu_data_input_steering_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cdis_pkg::*;
  logic mclk, rst_b, wv, wr, strobe, take_req, stall, crdy, oe, ov, tk, pt, wq;
  cdis_addr_t addr, al, e_a;
  cdis_stat_t stat, sl, s1, s2;
  cdis_byte_t wd, bo, pob, mb, pb, e_b;
  cdis_byte_t q[$];
  logic e_oe, e_rdy;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int live = 0;
  cdis_steer #(.FIFO_DEPTH(16)) dut (.mclk(mclk), .rst_b(rst_b), .cpu_addr(addr), .cpu_status(stat),
    .cpu_wdata(wd), .cpu_wvalid(wv), .cpu_wready(wr), .data_bus_in_strobe(strobe), .cpu_ready(crdy),
    .bidir_data_bus_i(8'h00), .bidir_data_bus_o(bo), .bidir_data_bus_oe(oe), .address_lines(al),
    .status_lines(sl), .processor_output_byte(pob), .output_byte_valid(ov), .output_byte_taken(tk),
    .memory_io_input_byte(mb), .wait_request_input(wq), .panel_takeover(pt), .panel_input_byte(pb));
  cdis_far_model far (.mclk(mclk), .rst_b(rst_b), .take_req(take_req), .stall(stall),
    .panel_takeover(pt), .memory_io_input_byte(mb), .panel_input_byte(pb),
    .wait_request_input(wq), .output_byte_taken(tk));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input logic w, input logic s);
    @(posedge mclk);
    addr <= 16'($urandom);
    stat <= 8'($urandom);
    wd <= 8'($urandom);
    strobe <= 1'($urandom);
    take_req <= 1'($urandom);
    wv <= w;
    stall <= s;
  endtask
  // ==========================================================
  // Reference model
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  // Inputs are read before this edge's updates land, as the design sees them.
  always @(posedge mclk) begin
    if (rst_b) live++;
    e_oe = strobe;
    e_b = pt ? pb : mb;
    e_a = addr;
    s2 = s1;
    s1 = stat;
    e_rdy = wq;
    if (wv && wr && rst_b) q.push_back(wd);
    if (ov && tk && live > 2) begin
      chk(pob, q[0], "write byte");
      void'(q.pop_front());
    end
  end
  always @(negedge mclk) begin
    if (live > 2) begin
      chk(oe, e_oe, "bus enable");
      chk(bo, e_oe ? e_b : 8'h00, "bus byte");
      chk(al, e_a, "address");
      chk(sl, s2, "status");
      chk(crdy, e_rdy, "ready");
      chk(wr, (q.size() - ov) < 16, "write ready");
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_b, wv, strobe, take_req, stall} = 5'h00;
    addr = 16'h0000;
    stat = 8'h00;
    wd = 8'h00;
    void'($urandom(12));
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (600) step(1'($urandom), 1'h0);
    // Overfill while the consumer stalls, then drain.
    repeat (30) step(1'h1, 1'h1);
    @(negedge mclk);
    chk(wr, 1'h0, "full refuses");
    repeat (200) step(1'h0, 1'h0);
    @(negedge mclk);
    chk(16'(q.size()), 16'h0000, "drained");
    chk(ov, 1'h0, "output empty");
    summarize();
  end
endmodule
